/* rtl/cpcr_regs.sv */
// cpu control and page register set with a wishbone register port
`timescale 1ns/1ps
module cpcr_regs (
	// clock and reset
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	// wishbone slave
	input  wire logic                  WB_CYC_I,
	input  wire logic                  WB_STB_I,
	input  wire logic                  WB_WE_I,
	input  wire logic [4:0]            WB_ADR_I,
	input  wire logic [3:0]            WB_SEL_I,
	input  wire logic [31:0]           WB_DAT_I,
	output logic      [31:0]           WB_DAT_O,
	output logic                       WB_ACK_O,
	output logic                       WB_ERR_O,
	// mode select pins
	input  wire logic [2:0]            BOOT_SELECT_PINS,
	// instruction flow
	input  wire logic                  INSTR_DONE,
	input  wire logic [15:0]           INSTR_NEXT_PC,
	output logic                       TRACE_REQ,
	// flag update from the datapath
	input  wire logic                  FLAG_WE,
	input  wire cpcr_pkg::cpcr_flags_t FLAG_IN,
	// interrupt requests
	input  wire logic                  IRQ_VALID,
	input  wire logic [2:0]            IRQ_LEVEL,
	input  wire logic                  NMI_REQ,
	input  wire logic                  FLASH_BUSY,
	output logic                       INT_ACCEPT,
	input  wire logic [15:0]           INT_VECTOR_PC,
	input  wire logic [7:0]            INT_VECTOR_BANK,
	// exception return and reset vector
	input  wire logic                  EXC_RETURN,
	input  wire logic [15:0]           RET_PC,
	input  wire logic [7:0]            RET_BANK,
	input  wire logic                  VEC_LOAD,
	input  wire logic [15:0]           VEC_PC,
	input  wire logic [7:0]            VEC_BANK,
	// load-control instruction
	input  wire logic                  LDC_WE,
	input  wire logic [2:0]            LDC_SEL,
	input  wire logic [7:0]            LDC_DATA,
	// effective address generation
	input  wire cpcr_pkg::cpcr_ea_t    EA_SRC,
	input  wire logic [15:0]           EA_OFFSET,
	output logic      [23:0]           FETCH_ADDR,
	output logic      [23:0]           EA_ADDR,
	// saved context for exception entry
	output logic      [15:0]           SAVE_PC,
	output logic      [7:0]            SAVE_BANK,
	// state
	output logic                       MAX_MODE,
	output logic      [2:0]            MASK_LEVEL
);
	parameter logic [2:0] MAX_MODE_SEL = 3'h1;

	logic [15:0]          next_instr_pointer;
	logic                 trace;
	logic [2:0]           mask;
	cpcr_pkg::cpcr_flags_t flags;
	cpcr_pkg::cpcr_pages_t pg;
	logic                 max_mode;
	logic [2:0]           pin_meta;
	logic [2:0]           pin_sync;
	logic                 strap_taken;
	logic [1:0]           strap_wait;
	logic [15:0]          status_word;
	logic                 accept;
	logic [2:0]           new_mask;
	logic                 wb_req;
	logic                 hit;
	logic                 wr;
	logic [31:0]          rdata;
	logic [15:0]          sr_wr;

	cpcr_int_gate u_gate (
		.irq_valid  (IRQ_VALID),
		.irq_level  (IRQ_LEVEL),
		.nmi_req    (NMI_REQ),
		.flash_busy (FLASH_BUSY),
		.mask       (mask),
		.accept     (accept),
		.new_mask   (new_mask)
	);

	assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
	always_comb begin
		hit = 1'b1;
		case (WB_ADR_I)
			cpcr_pkg::OFF_PC,
			cpcr_pkg::OFF_SR,
			cpcr_pkg::OFF_CODE,
			cpcr_pkg::OFF_DATA,
			cpcr_pkg::OFF_EXT,
			cpcr_pkg::OFF_STACK,
			cpcr_pkg::OFF_BASE,
			cpcr_pkg::OFF_STAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign wr = wb_req && hit && WB_WE_I;

	// status word image; reserved bits stay zero
	always_comb begin
		status_word = 16'h0000;
		status_word[cpcr_pkg::SR_TRACE] = trace;
		status_word[cpcr_pkg::SR_MASK_H:cpcr_pkg::SR_MASK_L] = mask;
		status_word[cpcr_pkg::SR_NEG]   = flags.neg;
		status_word[cpcr_pkg::SR_ZERO]  = flags.zero;
		status_word[cpcr_pkg::SR_OVF]   = flags.ovf;
		status_word[cpcr_pkg::SR_CARRY] = flags.carry;
	end

	// byte-lane merge so the flag byte can be written alone
	always_comb begin
		sr_wr = status_word;
		if (WB_SEL_I[0]) begin
			sr_wr[7:0] = WB_DAT_I[7:0];
		end
		if (WB_SEL_I[1]) begin
			sr_wr[15:8] = WB_DAT_I[15:8];
		end
		sr_wr = sr_wr & cpcr_pkg::SR_WMASK;
	end

	// boot select pins synchronised, then captured once after reset
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			pin_meta <= BOOT_SELECT_PINS;
			pin_sync <= pin_meta;
		end
	end

	// capture waits until both sync stages hold post-reset samples
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			strap_taken <= 1'b0;
			strap_wait  <= 2'h0;
			max_mode    <= 1'b0;
		end else if (!strap_taken) begin
			if (strap_wait == cpcr_pkg::STRAP_WAIT) begin
				strap_taken <= 1'b1;
				max_mode    <= (pin_sync == MAX_MODE_SEL);
			end else begin
				strap_wait <= strap_wait + 2'h1;
			end
		end
	end

	// instruction pointer
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			next_instr_pointer <= cpcr_pkg::PC_RST;
		end else if (VEC_LOAD) begin
			next_instr_pointer <= VEC_PC;
		end else if (accept) begin
			next_instr_pointer <= INT_VECTOR_PC;
		end else if (EXC_RETURN) begin
			next_instr_pointer <= RET_PC;
		end else if (INSTR_DONE) begin
			next_instr_pointer <= INSTR_NEXT_PC;
		end else if (wr && WB_ADR_I == cpcr_pkg::OFF_PC) begin
			if (WB_SEL_I[0]) begin
				next_instr_pointer[7:0] <= WB_DAT_I[7:0];
			end
			if (WB_SEL_I[1]) begin
				next_instr_pointer[15:8] <= WB_DAT_I[15:8];
			end
		end
	end

	// trace bit
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			trace <= 1'b0;
		end else if (wr && WB_ADR_I == cpcr_pkg::OFF_SR && WB_SEL_I[1]) begin
			trace <= sr_wr[cpcr_pkg::SR_TRACE];
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			TRACE_REQ <= 1'b0;
		end else begin
			TRACE_REQ <= trace && INSTR_DONE;
		end
	end

	// interrupt mask; acceptance beats a software write
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			mask <= cpcr_pkg::MASK_RST;
		end else if (accept) begin
			mask <= new_mask;
		end else if (wr && WB_ADR_I == cpcr_pkg::OFF_SR && WB_SEL_I[1]) begin
			mask <= sr_wr[cpcr_pkg::SR_MASK_H:cpcr_pkg::SR_MASK_L];
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			INT_ACCEPT <= 1'b0;
		end else begin
			INT_ACCEPT <= accept;
		end
	end

	// condition flags; datapath update beats a software write
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			flags <= '0;
		end else if (FLAG_WE) begin
			flags.neg   <= FLAG_IN.neg;
			flags.zero  <= FLAG_IN.zero;
			flags.ovf   <= FLAG_IN.ovf;
			flags.carry <= FLAG_IN.carry;
		end else if (wr && WB_ADR_I == cpcr_pkg::OFF_SR && WB_SEL_I[0]) begin
			flags.neg   <= sr_wr[cpcr_pkg::SR_NEG];
			flags.zero  <= sr_wr[cpcr_pkg::SR_ZERO];
			flags.ovf   <= sr_wr[cpcr_pkg::SR_OVF];
			flags.carry <= sr_wr[cpcr_pkg::SR_CARRY];
		end
	end

	// code bank
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pg.code_bank <= cpcr_pkg::PAGE_RST;
		end else if (VEC_LOAD && max_mode) begin
			pg.code_bank <= VEC_BANK;
		end else if (accept && max_mode) begin
			pg.code_bank <= INT_VECTOR_BANK;
		end else if (EXC_RETURN && max_mode) begin
			pg.code_bank <= RET_BANK;
		end else if (LDC_WE && LDC_SEL == 3'h0) begin
			pg.code_bank <= LDC_DATA;
		end else if (wr && WB_ADR_I == cpcr_pkg::OFF_CODE && WB_SEL_I[0]) begin
			pg.code_bank <= WB_DAT_I[7:0];
		end
	end

	// remaining page and base registers: one per load-control select
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pg.data_bank     <= cpcr_pkg::PAGE_RST;
			pg.extended_bank <= cpcr_pkg::PAGE_RST;
			pg.stack_bank    <= cpcr_pkg::PAGE_RST;
			pg.short_base    <= cpcr_pkg::PAGE_RST;
		end else if (LDC_WE) begin
			case (LDC_SEL)
				3'h1: pg.data_bank     <= LDC_DATA;
				3'h2: pg.extended_bank <= LDC_DATA;
				3'h3: pg.stack_bank    <= LDC_DATA;
				3'h4: pg.short_base    <= LDC_DATA;
				default: ;
			endcase
		end else if (wr && WB_SEL_I[0]) begin
			case (WB_ADR_I)
				cpcr_pkg::OFF_DATA:  pg.data_bank     <= WB_DAT_I[7:0];
				cpcr_pkg::OFF_EXT:   pg.extended_bank <= WB_DAT_I[7:0];
				cpcr_pkg::OFF_STACK: pg.stack_bank    <= WB_DAT_I[7:0];
				cpcr_pkg::OFF_BASE:  pg.short_base    <= WB_DAT_I[7:0];
				default: ;
			endcase
		end
	end

	// address generation; banks take part only in maximum mode
	always_comb begin
		FETCH_ADDR = {max_mode ? pg.code_bank : 8'h00,
			next_instr_pointer};
		case (EA_SRC)
			cpcr_pkg::CPCR_EA_CODE:
				EA_ADDR = {max_mode ? pg.code_bank : 8'h00, EA_OFFSET};
			cpcr_pkg::CPCR_EA_R0_R3,
			cpcr_pkg::CPCR_EA_ABS:
				EA_ADDR = {max_mode ? pg.data_bank : 8'h00,
					EA_OFFSET};
			cpcr_pkg::CPCR_EA_R4_R5:
				EA_ADDR = {max_mode ? pg.extended_bank : 8'h00,
					EA_OFFSET};
			cpcr_pkg::CPCR_EA_R6_R7,
			cpcr_pkg::CPCR_EA_STACK:
				EA_ADDR = {max_mode ? pg.stack_bank : 8'h00,
					EA_OFFSET};
			cpcr_pkg::CPCR_EA_SHORT:
				EA_ADDR = {8'h00, pg.short_base, EA_OFFSET[7:0]};
			default: EA_ADDR = {8'h00, EA_OFFSET};
		endcase
	end

	// context saved on exception entry
	assign SAVE_PC   = next_instr_pointer;
	assign SAVE_BANK = pg.code_bank;
	assign MAX_MODE   = max_mode;
	assign MASK_LEVEL = mask;

	// read mux
	always_comb begin
		rdata = 32'h0000_0000;
		case (WB_ADR_I)
			cpcr_pkg::OFF_PC:    rdata[15:0] = next_instr_pointer;
			cpcr_pkg::OFF_SR:    rdata[15:0] = status_word;
			cpcr_pkg::OFF_CODE:  rdata[7:0]  = pg.code_bank;
			cpcr_pkg::OFF_DATA:  rdata[7:0]  = pg.data_bank;
			cpcr_pkg::OFF_EXT:   rdata[7:0]  = pg.extended_bank;
			cpcr_pkg::OFF_STACK: rdata[7:0]  = pg.stack_bank;
			cpcr_pkg::OFF_BASE:  rdata[7:0]  = pg.short_base;
			cpcr_pkg::OFF_STAT:  rdata[0]    = max_mode;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// one-cycle answer, registered
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_ERR_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_req && hit;
			WB_ERR_O <= wb_req && !hit;
			WB_DAT_O <= (wb_req && hit && !WB_WE_I) ? rdata : 32'h0000_0000;
		end
	end
endmodule

/* inc/cpcr_pkg.sv */
// shared constants and carrier types for the cpu control register set
package cpcr_pkg;

	// wishbone word offsets (byte addresses)
	localparam logic [4:0] OFF_PC     = 5'h00;
	localparam logic [4:0] OFF_SR     = 5'h04;
	localparam logic [4:0] OFF_CODE   = 5'h08;
	localparam logic [4:0] OFF_DATA   = 5'h0C;
	localparam logic [4:0] OFF_EXT    = 5'h10;
	localparam logic [4:0] OFF_STACK  = 5'h14;
	localparam logic [4:0] OFF_BASE   = 5'h18;
	localparam logic [4:0] OFF_STAT   = 5'h1C;

	// status word field positions
	localparam int SR_TRACE  = 15;
	localparam int SR_MASK_H = 10;
	localparam int SR_MASK_L = 8;
	localparam int SR_NEG    = 3;
	localparam int SR_ZERO   = 2;
	localparam int SR_OVF    = 1;
	localparam int SR_CARRY  = 0;

	// writable bits of the status word
	localparam logic [15:0] SR_WMASK = 16'h870F;

	// reset values
	localparam logic [15:0] PC_RST   = 16'h0000;
	localparam logic [2:0]  MASK_RST = 3'h7;
	localparam logic [7:0]  PAGE_RST = 8'h00;

	// edges after reset before the synchronised mode pins are trusted
	localparam logic [1:0]  STRAP_WAIT = 2'h2;

	// interrupt levels
	localparam logic [3:0]  NMI_LEVEL = 4'h8;
	localparam logic [2:0]  MASK_MAX  = 3'h7;

	// effective address source selection
	typedef enum logic [2:0] {
		CPCR_EA_CODE,
		CPCR_EA_R0_R3,
		CPCR_EA_ABS,
		CPCR_EA_R4_R5,
		CPCR_EA_R6_R7,
		CPCR_EA_STACK,
		CPCR_EA_SHORT
	} cpcr_ea_t;

	// condition flags produced by the datapath
	typedef struct packed {
		logic neg;
		logic zero;
		logic ovf;
		logic carry;
	} cpcr_flags_t;

	// page register set
	typedef struct packed {
		logic [7:0] code_bank;
		logic [7:0] data_bank;
		logic [7:0] extended_bank;
		logic [7:0] stack_bank;
		logic [7:0] short_base;
	} cpcr_pages_t;

endpackage

/* rtl/cpcr_int_gate.sv */
// interrupt acceptance gate against the current mask level
`timescale 1ns/1ps
module cpcr_int_gate (
	// request side
	input  wire logic       irq_valid,
	input  wire logic [2:0] irq_level,
	input  wire logic       nmi_req,
	input  wire logic       flash_busy,
	// mask
	input  wire logic [2:0] mask,
	// result
	output logic            accept,
	output logic [2:0]      new_mask
);
	logic nmi_ok;
	logic irq_ok;

	assign nmi_ok = nmi_req && !flash_busy;
	assign irq_ok = irq_valid && (irq_level > mask);
	assign accept = nmi_ok || irq_ok;
	// nmi wins and forces the mask to its top value
	assign new_mask = nmi_ok ? cpcr_pkg::MASK_MAX : irq_level;
endmodule

/* verif/cpcr_regs_chk.sv */
// assertion checker for the cpu control register set
`timescale 1ns/1ps
module cpcr_regs_chk (
	// clock and reset
	input wire logic               CLOCK,
	input wire logic               RST,
	// core side
	input wire logic               INSTR_DONE,
	input wire logic               TRACE_REQ,
	input wire logic               IRQ_VALID,
	input wire logic [2:0]         IRQ_LEVEL,
	input wire logic               NMI_REQ,
	input wire logic               FLASH_BUSY,
	input wire logic               INT_ACCEPT,
	input wire logic [2:0]         MASK_LEVEL,
	// addressing
	input wire cpcr_pkg::cpcr_ea_t EA_SRC,
	input wire logic [15:0]        EA_OFFSET,
	input wire logic [23:0]        EA_ADDR,
	input wire logic [23:0]        FETCH_ADDR,
	input wire logic [15:0]        SAVE_PC,
	input wire logic               MAX_MODE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	sequence nmi_open_s;
		NMI_REQ && !FLASH_BUSY && !INT_ACCEPT;
	endsequence
	sequence took_s;
		INT_ACCEPT && !$past(NMI_REQ && !FLASH_BUSY);
	endsequence
	mask_reset_a: assert property ($fell(RST) |-> MASK_LEVEL == 3'h7)
		else $error("mask not seven after reset");
	trace_src_a: assert property (TRACE_REQ |-> $past(INSTR_DONE))
		else $error("trace request without retired instruction");
	level_gt_a: assert property (took_s
		|-> $past(IRQ_VALID && IRQ_LEVEL > MASK_LEVEL))
		else $error("interrupt accepted at or below mask");
	mask_load_a: assert property (took_s
		|-> MASK_LEVEL == $past(IRQ_LEVEL))
		else $error("mask not loaded with accepted level");
	nmi_mask_a: assert property (INT_ACCEPT
		&& $past(NMI_REQ && !FLASH_BUSY) |-> MASK_LEVEL == 3'h7)
		else $error("mask not seven after nmi");
	nmi_take_a: assert property (nmi_open_s |=> INT_ACCEPT)
		else $error("nmi not accepted");
	nmi_block_a: assert property (FLASH_BUSY && NMI_REQ
		&& !IRQ_VALID |=> !INT_ACCEPT)
		else $error("nmi accepted during flash busy");
	short_page_a: assert property (EA_SRC == cpcr_pkg::CPCR_EA_SHORT
		|-> EA_ADDR == {8'h00, EA_ADDR[15:8], EA_OFFSET[7:0]})
		else $error("short absolute address off page zero");
	min_page_a: assert property (!MAX_MODE
		|-> EA_ADDR[23:16] == 8'h00 && FETCH_ADDR[23:16] == 8'h00)
		else $error("page bits used in minimum mode");
	fetch_low_a: assert property (FETCH_ADDR[15:0] == SAVE_PC)
		else $error("fetch address not pointer");
endmodule
bind cpcr_regs cpcr_regs_chk chk (.CLOCK(CLOCK), .RST(RST),
	.INSTR_DONE(INSTR_DONE), .TRACE_REQ(TRACE_REQ), .IRQ_VALID(IRQ_VALID),
	.IRQ_LEVEL(IRQ_LEVEL), .NMI_REQ(NMI_REQ), .FLASH_BUSY(FLASH_BUSY),
	.INT_ACCEPT(INT_ACCEPT), .MASK_LEVEL(MASK_LEVEL), .EA_SRC(EA_SRC),
	.EA_OFFSET(EA_OFFSET), .EA_ADDR(EA_ADDR), .FETCH_ADDR(FETCH_ADDR),
	.SAVE_PC(SAVE_PC), .MAX_MODE(MAX_MODE));

/* verif/cpcr_irq_src.sv */
// interrupt requester on the far side of the mask gate
`timescale 1ns/1ps
module cpcr_irq_src (
	// clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RST,
	// bench control
	input  wire logic       req,
	input  wire logic       nmi,
	input  wire logic [2:0] lvl,
	// core side
	input  wire logic       INT_ACCEPT,
	output logic            IRQ_VALID,
	output logic [2:0]      IRQ_LEVEL,
	output logic            NMI_REQ
);
	logic served;
	// a served request is withdrawn until the bench lowers it
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST)
			served <= 1'b0;
		else if (INT_ACCEPT)
			served <= 1'b1;
		else if (!req)
			served <= 1'b0;
	end
	// drop as soon as acceptance shows, so one request is taken once
	assign IRQ_VALID = req && !nmi && !served && !INT_ACCEPT;
	assign NMI_REQ   = req && nmi && !served && !INT_ACCEPT;
	// idle level lines show the inverse, never the stale level
	assign IRQ_LEVEL = IRQ_VALID ? lvl : ~lvl;
endmodule

/* verif/test_cpu_control_page_registers.sv */
// self-checking bench for the cpu control register set
`timescale 1ns/1ps
module test_cpu_control_page_registers;
	logic        CLOCK = 0, RST = 1, cyc = 0, stb = 0, we = 0, busy = 0;
	logic        i_done = 0, f_we = 0, p_req = 0, p_nmi = 0, v_ld = 0;
	logic        x_ret = 0, l_we = 0, ack, err, rerr, trc, acc, mmode;
	logic        ivalid, nmi_r;
	logic [2:0]  p_lvl = 0, l_sel = 0, mask, ilvl, pins = 3'h1;
	logic [3:0]  sel = 0;
	logic [4:0]  adr = 0;
	logic [7:0]  l_dat = 0, bnk_in = 0, sbank;
	logic [15:0] pc_in = 0, ea_off = 0, save_pc;
	logic [23:0] fetch, ea, x;
	logic [31:0] wdat = 0, rdat, dato;
	cpcr_pkg::cpcr_flags_t flg = 0;
	cpcr_pkg::cpcr_ea_t    ea_src = cpcr_pkg::CPCR_EA_CODE;
	int err_count = 0, check_count = 0, seed = 57, cyc_n = 0, m_mask, d;
	int bank[5], bi[7] = '{0, 1, 1, 2, 3, 3, 4};
	always #12.5 CLOCK = ~CLOCK;
	cpcr_regs dut (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(dato), .WB_ACK_O(ack), .WB_ERR_O(err),
		.BOOT_SELECT_PINS(pins), .INSTR_DONE(i_done), .INSTR_NEXT_PC(pc_in),
		.TRACE_REQ(trc), .FLAG_WE(f_we), .FLAG_IN(flg), .IRQ_VALID(ivalid),
		.IRQ_LEVEL(ilvl), .NMI_REQ(nmi_r), .FLASH_BUSY(busy),
		.INT_ACCEPT(acc), .INT_VECTOR_PC(16'h0000), .INT_VECTOR_BANK(8'h00),
		.EXC_RETURN(x_ret), .RET_PC(pc_in), .RET_BANK(bnk_in),
		.VEC_LOAD(v_ld), .VEC_PC(pc_in), .VEC_BANK(bnk_in), .LDC_WE(l_we),
		.LDC_SEL(l_sel), .LDC_DATA(l_dat), .EA_SRC(ea_src),
		.EA_OFFSET(ea_off), .FETCH_ADDR(fetch), .EA_ADDR(ea),
		.SAVE_PC(save_pc), .SAVE_BANK(sbank), .MAX_MODE(mmode),
		.MASK_LEVEL(mask));
	cpcr_irq_src src (.CLOCK(CLOCK), .RST(RST), .req(p_req), .nmi(p_nmi),
		.lvl(p_lvl), .INT_ACCEPT(acc), .IRQ_VALID(ivalid), .IRQ_LEVEL(ilvl),
		.NMI_REQ(nmi_r));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [3:0] s, input logic [31:0] v);
		@(posedge CLOCK);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= v;
		do @(posedge CLOCK); while (ack !== 1'b1 && err !== 1'b1);
		rdat = dato;
		rerr = err;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task automatic irq(input int lv, input bit nm, input bit bz);
		logic got, ex;
		got = 0;
		@(posedge CLOCK);
		p_lvl <= 3'(lv);
		p_nmi <= nm;
		p_req <= 1;
		busy <= bz;
		repeat (6) begin
			@(posedge CLOCK);
			if (acc === 1'b1)
				got = 1;
		end
		p_req <= 0;
		busy <= 0;
		ex = nm ? !bz : lv > m_mask;
		if (ex)
			m_mask = nm ? 7 : lv;
		chk("accept", got, ex);
		@(negedge CLOCK);
		chk("mask", mask, m_mask);
	endtask
	always @(posedge CLOCK) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		repeat (3) @(posedge CLOCK);
		RST <= 0;
		repeat (4) @(posedge CLOCK);
		wb(0, cpcr_pkg::OFF_SR, 4'hF, 0);
		chk("status", rdat, 32'h0700);
		wb(0, cpcr_pkg::OFF_STAT, 4'hF, 0);
		chk("mode", rdat, 32'h1);
		wb(1, cpcr_pkg::OFF_SR, 4'h3, 32'hFFFF);
		wb(0, cpcr_pkg::OFF_SR, 4'hF, 0);
		chk("status", rdat, 32'h870F);
		wb(1, cpcr_pkg::OFF_SR, 4'h1, 0);
		wb(0, cpcr_pkg::OFF_SR, 4'hF, 0);
		chk("status", rdat, 32'h8700);
		wb(0, 5'h1E, 4'hF, 0);
		chk("unmapped", rerr, 1);
		wb(1, cpcr_pkg::OFF_SR, 4'h3, 0);
		repeat (4) begin
			d = $random(seed);
			@(posedge CLOCK);
			f_we <= 1;
			flg <= d[3:0];
			@(posedge CLOCK);
			f_we <= 0;
			wb(0, cpcr_pkg::OFF_SR, 4'hF, 0);
			chk("flags", rdat, d[3:0]);
		end
		for (int i = 0; i < 5; i++) begin
			d = $random(seed);
			bank[i] = d[7:0];
			@(posedge CLOCK);
			l_we <= 1;
			l_sel <= 3'(i);
			l_dat <= d[7:0];
			@(posedge CLOCK);
			l_we <= 0;
			wb(0, 5'(8 + 4 * i), 4'hF, 0);
			chk("bank", rdat, bank[i]);
		end
		for (int e = 0; e < 7; e++) begin
			d = $random(seed);
			@(posedge CLOCK);
			ea_src <= cpcr_pkg::cpcr_ea_t'(e);
			ea_off <= d[15:0];
			@(negedge CLOCK);
			x = {bank[bi[e]][7:0], d[15:0]};
			if (e == 6)
				x = {8'h00, bank[4][7:0], d[7:0]};
			chk("ea", ea, x);
		end
		chk("fetch bank", fetch[23:16], bank[0]);
		for (int t = 0; t < 2; t++) begin
			wb(1, cpcr_pkg::OFF_SR, 4'h2, t ? 32'h0 : 32'h8000);
			d = $random(seed);
			@(posedge CLOCK);
			i_done <= 1;
			pc_in <= d[15:0];
			@(posedge CLOCK);
			i_done <= 0;
			@(negedge CLOCK);
			chk("trace", trc, t == 0);
			chk("pointer", fetch[15:0], d[15:0]);
		end
		for (int i = 0; i < 2; i++) begin
			d = $random(seed);
			@(posedge CLOCK);
			pc_in <= d[15:0];
			bnk_in <= d[23:16];
			v_ld <= i == 0;
			x_ret <= i == 1;
			@(posedge CLOCK);
			v_ld <= 0;
			x_ret <= 0;
			@(negedge CLOCK);
			chk("fetch", fetch, d[23:0]);
			chk("saved bank", sbank, d[23:16]);
			chk("saved pc", save_pc, d[15:0]);
		end
		for (int mk = 0; mk < 8; mk++)
			for (int lv = 1; lv < 8; lv++) begin
				wb(1, cpcr_pkg::OFF_SR, 4'h2, mk << 8);
				m_mask = mk;
				irq(lv, 0, 0);
			end
		wb(1, cpcr_pkg::OFF_SR, 4'h2, 0);
		m_mask = 0;
		irq(0, 1, 1);
		irq(0, 1, 0);
		@(posedge CLOCK);
		RST <= 1;
		pins <= 3'h0;
		repeat (3) @(posedge CLOCK);
		RST <= 0;
		repeat (4) @(posedge CLOCK);
		chk("max mode", mmode, 0);
		wb(0, cpcr_pkg::OFF_STAT, 4'hF, 0);
		chk("mode", rdat, 32'h0);
		wb(0, cpcr_pkg::OFF_SR, 4'hF, 0);
		chk("status", rdat, 32'h0700);
		@(posedge CLOCK);
		l_we <= 1;
		l_sel <= 3'h0;
		l_dat <= 8'hA5;
		ea_src <= cpcr_pkg::CPCR_EA_CODE;
		@(posedge CLOCK);
		l_we <= 0;
		wb(0, cpcr_pkg::OFF_CODE, 4'hF, 0);
		chk("bank", rdat, 32'hA5);
		@(negedge CLOCK);
		chk("min ea", ea, {8'h00, ea_off});
		chk("min fetch", fetch[23:16], 0);
		close_out;
	end
endmodule
